// ==== crs_byte_alu.sv ====
// Eight-bit arithmetic and logic unit with its flag results.
`timescale 1ns/1ns
`default_nettype none
module crs_byte_alu (
	input wire crs_pkg::crs_alu_op_e op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic c_in,
	input wire logic h_in,
	output logic [7:0] res,
	output logic res_we,
	output logic upd_v,
	output logic upd_h,
	output logic upd_c,
	output logic v,
	output logic h,
	output logic c
);
	logic [8:0] wide;
	logic [7:0] fix;
	logic cy;

	always_comb begin
		wide = 9'h000;
		fix = 8'h00;
		cy = (op == crs_pkg::ALU_ADC || op == crs_pkg::ALU_SBC) ? c_in : 1'b0;
		res = a;
		res_we = 1'b1;
		upd_v = 1'b1;
		upd_h = 1'b0;
		upd_c = 1'b1;
		v = 1'b0;
		h = 1'b0;
		c = 1'b0;
		case (op)
			crs_pkg::ALU_ADD, crs_pkg::ALU_ADC: begin
				wide = {1'b0, a} + {1'b0, b} + {8'h00, cy};
				res = wide[7:0];
				c = wide[8];
				// The carry into bit 4 is the half carry; bit 3 alone would give the carry into bit 3.
				h = a[4] ^ b[4] ^ res[4];
				upd_h = 1'b1;
				v = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
			end
			crs_pkg::ALU_SUB, crs_pkg::ALU_SBC, crs_pkg::ALU_CMP: begin
				wide = {1'b0, a} - {1'b0, b} - {8'h00, cy};
				res = wide[7:0];
				res_we = (op != crs_pkg::ALU_CMP);
				c = wide[8];
				v = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
			end
			crs_pkg::ALU_AND: begin
				res = a & b;
				upd_c = 1'b0;
			end
			crs_pkg::ALU_ORA: begin
				res = a | b;
				upd_c = 1'b0;
			end
			crs_pkg::ALU_EOR: begin
				res = a ^ b;
				upd_c = 1'b0;
			end
			crs_pkg::ALU_LOAD: begin
				res = b;
				upd_c = 1'b0;
			end
			crs_pkg::ALU_CLR: begin
				res = 8'h00;
				upd_c = 1'b0;
			end
			crs_pkg::ALU_INC: begin
				res = a + 8'h01;
				v = (res == 8'h80);
				upd_c = 1'b0;
			end
			crs_pkg::ALU_DEC: begin
				res = a - 8'h01;
				v = (res == 8'h7f);
				upd_c = 1'b0;
			end
			crs_pkg::ALU_COM: begin
				res = ~a;
				c = 1'b1;
			end
			crs_pkg::ALU_NEG: begin
				res = 8'h00 - a;
				v = (res == 8'h80);
				c = (res != 8'h00);
			end
			crs_pkg::ALU_LSL, crs_pkg::ALU_ROL: begin
				res = {a[6:0], (op == crs_pkg::ALU_ROL) ? c_in : 1'b0};
				c = a[7];
				v = res[7] ^ a[7];
			end
			crs_pkg::ALU_LSR, crs_pkg::ALU_ASR, crs_pkg::ALU_ROR: begin
				res = {(op == crs_pkg::ALU_ROR) ? c_in : ((op == crs_pkg::ALU_ASR) ? a[7] : 1'b0), a[7:1]};
				c = a[0];
				v = res[7] ^ a[0];
			end
			crs_pkg::ALU_DAA: begin
				// Correction follows the flags left by the previous add.
				if (h_in || a[3:0] > crs_pkg::BCD_DIGIT_MAX) begin
					fix = fix | crs_pkg::BCD_LO_FIX;
				end
				if (c_in || a > crs_pkg::BCD_MAX) begin
					fix = fix | crs_pkg::BCD_HI_FIX;
				end
				res = a + fix;
				c = c_in | (a > crs_pkg::BCD_MAX);
				upd_v = 1'b0;
			end
			default: begin
				res_we = 1'b0;
				upd_v = 1'b0;
				upd_c = 1'b0;
			end
		endcase
	end
endmodule // crs_byte_alu
`default_nettype wire

// ==== crs_pkg.sv ====
// Constants, types and encodings shared by the processor register set.
package crs_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;

	localparam logic [7:0] IDX_HI_RST = 8'h00;
	localparam logic [15:0] SP_RST = 16'h00ff;
	localparam logic [15:0] VEC_HI_ADDR = 16'hfffe;
	localparam logic [15:0] VEC_LO_ADDR = 16'hffff;
	localparam logic [7:0] FLAGS_RST = 8'h68;
	localparam logic [7:0] FLAGS_ONES = 8'h60;

	localparam int FLG_V = 7;
	localparam int FLG_H = 4;
	localparam int FLG_I = 3;
	localparam int FLG_N = 2;
	localparam int FLG_Z = 1;
	localparam int FLG_C = 0;

	localparam logic [2:0] REG_ACC = 3'h0;
	localparam logic [2:0] REG_IDX_LO = 3'h1;
	localparam logic [2:0] REG_IDX_HI = 3'h2;
	localparam logic [2:0] REG_SP_HI = 3'h3;
	localparam logic [2:0] REG_SP_LO = 3'h4;
	localparam logic [2:0] REG_PC_HI = 3'h5;
	localparam logic [2:0] REG_PC_LO = 3'h6;
	localparam logic [2:0] REG_FLAGS = 3'h7;

	localparam logic [7:0] STACK_LOW_RST = 8'hff;
	localparam logic [7:0] BCD_LO_FIX = 8'h06;
	localparam logic [7:0] BCD_HI_FIX = 8'h60;
	localparam logic [7:0] BCD_MAX = 8'h99;
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;

	typedef enum logic [1:0] {
		VEC_HI = 2'b00,
		VEC_LO = 2'b01,
		VEC_WAIT = 2'b11,
		RUN = 2'b10
	} crs_boot_e;

	typedef enum logic [4:0] {
		ALU_ADD = 5'h00,
		ALU_ADC = 5'h01,
		ALU_SUB = 5'h02,
		ALU_SBC = 5'h03,
		ALU_CMP = 5'h04,
		ALU_AND = 5'h05,
		ALU_ORA = 5'h06,
		ALU_EOR = 5'h07,
		ALU_LOAD = 5'h08,
		ALU_CLR = 5'h09,
		ALU_INC = 5'h0a,
		ALU_DEC = 5'h0b,
		ALU_COM = 5'h0c,
		ALU_NEG = 5'h0d,
		ALU_LSL = 5'h0e,
		ALU_LSR = 5'h0f,
		ALU_ASR = 5'h10,
		ALU_ROL = 5'h11,
		ALU_ROR = 5'h12,
		ALU_DAA = 5'h13
	} crs_alu_op_e;

endpackage

// ==== crs_regset.sv ====
// Architectural register set: accumulator, index pair, stack pointer, program counter and flags.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module crs_regset (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic alu_go,
	input wire crs_pkg::crs_alu_op_e alu_op,
	input wire logic alu_to_idx,
	input wire logic [7:0] alu_operand,
	input wire logic ld16_go,
	input wire logic ld16_to_sp,
	input wire logic [15:0] ld16_data,
	input wire logic st_go,
	input wire logic st_wide,
	input wire logic [15:0] st_data,
	input wire logic idx_post_inc,
	input wire logic add_imm_to_stack,
	input wire logic [7:0] stack_imm,
	input wire logic stack_low_reset_op,
	input wire logic sp_push,
	input wire logic sp_pull,
	input wire logic pc_fetch,
	input wire logic pc_load,
	input wire logic [15:0] pc_target,
	input wire logic [7:0] mem_rdata,
	input wire logic clear_mask_op,
	input wire logic set_mask_op,
	input wire logic acc_to_flags_op,
	input wire logic irq_take,
	input wire logic irq_pending,
	input wire logic instr_done,
	input wire logic carry_set_go,
	input wire logic carry_val,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_r,
	output logic [7:0] acc_r,
	output logic [7:0] idx_hi_r,
	output logic [7:0] idx_lo_r,
	output logic [15:0] stack_ptr_r,
	output logic [15:0] prog_counter_r,
	output logic [7:0] cond_flags_reg_r,
	output logic branch_greater_op_r,
	output logic branch_greater_equal_op_r,
	output logic branch_less_equal_op_r,
	output logic branch_less_op_r,
	output logic irq_ok_r,
	output logic vec_rd_r,
	output logic [15:0] vec_addr_r,
	output logic core_ready_r
);
	crs_pkg::crs_boot_e boot_r;
	logic [7:0] vec_hi_r;
	logic [7:0] alu_a;
	logic [7:0] alu_res;
	logic alu_we;
	logic alu_uv;
	logic alu_uh;
	logic alu_uc;
	logic alu_v;
	logic alu_h;
	logic alu_c;
	logic [7:0] flags_nxt;
	logic [15:0] mv_val;
	logic inhib_r;
	logic inhib_nxt;
	logic ge_nxt;
	logic zero_nxt;
	logic wr_acc;
	logic wr_lo;
	logic wr_hi;
	logic wr_sph;
	logic wr_spl;
	logic wr_pch;
	logic wr_pcl;
	logic wr_flg;

	// Software writes are decoded once and yield to the sequencer, except that a flags write beats carry_set_go, the mask ops and irq_take.
	always_comb begin
		wr_acc = 1'b0;
		wr_lo = 1'b0;
		wr_hi = 1'b0;
		wr_sph = 1'b0;
		wr_spl = 1'b0;
		wr_pch = 1'b0;
		wr_pcl = 1'b0;
		wr_flg = 1'b0;
		if (reg_wr && reg_addr == crs_pkg::REG_ACC) begin
			wr_acc = 1'b1;
		end else if (reg_wr && reg_addr == crs_pkg::REG_IDX_LO) begin
			wr_lo = 1'b1;
		end else if (reg_wr && reg_addr == crs_pkg::REG_IDX_HI) begin
			wr_hi = 1'b1;
		end else if (reg_wr && reg_addr == crs_pkg::REG_SP_HI) begin
			wr_sph = 1'b1;
		end else if (reg_wr && reg_addr == crs_pkg::REG_SP_LO) begin
			wr_spl = 1'b1;
		end else if (reg_wr && reg_addr == crs_pkg::REG_PC_HI) begin
			wr_pch = 1'b1;
		end else if (reg_wr && reg_addr == crs_pkg::REG_PC_LO) begin
			wr_pcl = 1'b1;
		end else if (reg_wr) begin
			wr_flg = 1'b1;
		end
	end

	assign alu_a = alu_to_idx ? idx_lo_r : acc_r;

	crs_byte_alu u_alu (
		.op(alu_op),
		.a(alu_a),
		.b(alu_operand),
		.c_in(cond_flags_reg_r[crs_pkg::FLG_C]),
		.h_in(cond_flags_reg_r[crs_pkg::FLG_H]),
		.res(alu_res),
		.res_we(alu_we),
		.upd_v(alu_uv),
		.upd_h(alu_uh),
		.upd_c(alu_uc),
		.v(alu_v),
		.h(alu_h),
		.c(alu_c)
	);

	// No reset term: the accumulator keeps whatever it held across a reset.
	always_ff @(posedge sys_clk) begin
		if (alu_go && !alu_to_idx && alu_we) begin
			acc_r <= alu_res;
		end else if (wr_acc) begin
			acc_r <= reg_wdata;
		end
	end

	// The low index byte is also left alone by reset.
	always_ff @(posedge sys_clk) begin
		if (alu_go && alu_to_idx && alu_we) begin
			idx_lo_r <= alu_res;
		end else if (ld16_go && !ld16_to_sp) begin
			idx_lo_r <= ld16_data[7:0];
		end else if (idx_post_inc) begin
			idx_lo_r <= idx_lo_r + 8'h01;
		end else if (wr_lo) begin
			idx_lo_r <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			idx_hi_r <= crs_pkg::IDX_HI_RST;
		end else if (ld16_go && !ld16_to_sp) begin
			idx_hi_r <= ld16_data[15:8];
		end else if (idx_post_inc && idx_lo_r == 8'hff) begin
			idx_hi_r <= idx_hi_r + 8'h01;
		end else if (wr_hi) begin
			idx_hi_r <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stack_ptr_r <= crs_pkg::SP_RST;
		end else if (ld16_go && ld16_to_sp) begin
			stack_ptr_r <= ld16_data;
		end else if (add_imm_to_stack) begin
			stack_ptr_r <= stack_ptr_r + {{8{stack_imm[7]}}, stack_imm};
		end else if (stack_low_reset_op) begin
			stack_ptr_r[7:0] <= crs_pkg::STACK_LOW_RST;
		end else if (sp_push) begin
			stack_ptr_r <= stack_ptr_r - 16'h0001;
		end else if (sp_pull) begin
			stack_ptr_r <= stack_ptr_r + 16'h0001;
		end else if (wr_sph) begin
			stack_ptr_r[15:8] <= reg_wdata;
		end else if (wr_spl) begin
			stack_ptr_r[7:0] <= reg_wdata;
		end
	end

	// Vector fetch: address out, data back one cycle later, then run.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			boot_r <= crs_pkg::VEC_HI;
			vec_rd_r <= 1'b1;
			vec_addr_r <= crs_pkg::VEC_HI_ADDR;
			vec_hi_r <= 8'h00;
			core_ready_r <= 1'b0;
		end else begin
			case (boot_r)
				crs_pkg::VEC_HI: begin
					boot_r <= crs_pkg::VEC_LO;
					vec_addr_r <= crs_pkg::VEC_LO_ADDR;
				end
				crs_pkg::VEC_LO: begin
					boot_r <= crs_pkg::VEC_WAIT;
					vec_hi_r <= mem_rdata;
					vec_rd_r <= 1'b0;
				end
				crs_pkg::VEC_WAIT: begin
					boot_r <= crs_pkg::RUN;
					core_ready_r <= 1'b1;
				end
				default: begin
					boot_r <= crs_pkg::RUN;
				end
			endcase
		end
	end

	// Sequencer requests on the program counter count only once the vector is in.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prog_counter_r <= 16'h0000;
		end else if (boot_r == crs_pkg::VEC_WAIT) begin
			prog_counter_r <= {vec_hi_r, mem_rdata};
		end else if (boot_r != crs_pkg::RUN) begin
			prog_counter_r <= prog_counter_r;
		end else if (pc_load) begin
			prog_counter_r <= pc_target;
		end else if (pc_fetch) begin
			prog_counter_r <= prog_counter_r + 16'h0001;
		end else if (wr_pch) begin
			prog_counter_r[15:8] <= reg_wdata;
		end else if (wr_pcl) begin
			prog_counter_r[7:0] <= reg_wdata;
		end
	end

	always_comb begin
		mv_val = ld16_go ? ld16_data : (st_wide ? st_data : {8'h00, st_data[7:0]});
		zero_nxt = (mv_val == 16'h0000);
		flags_nxt = cond_flags_reg_r;
		if (alu_go) begin
			if (alu_uv) begin
				flags_nxt[crs_pkg::FLG_V] = alu_v;
			end
			if (alu_uh) begin
				flags_nxt[crs_pkg::FLG_H] = alu_h;
			end
			if (alu_uc) begin
				flags_nxt[crs_pkg::FLG_C] = alu_c;
			end
			flags_nxt[crs_pkg::FLG_N] = alu_res[7];
			flags_nxt[crs_pkg::FLG_Z] = (alu_res == 8'h00);
		end else if (ld16_go || st_go) begin
			flags_nxt[crs_pkg::FLG_V] = 1'b0;
			flags_nxt[crs_pkg::FLG_N] = (ld16_go || st_wide) ? mv_val[15] : mv_val[7];
			flags_nxt[crs_pkg::FLG_Z] = zero_nxt;
		end
		if (carry_set_go) begin
			flags_nxt[crs_pkg::FLG_C] = carry_val;
		end
		if (acc_to_flags_op) begin
			flags_nxt = acc_r;
		end
		if (clear_mask_op) begin
			flags_nxt[crs_pkg::FLG_I] = 1'b0;
		end
		if (set_mask_op || irq_take) begin
			flags_nxt[crs_pkg::FLG_I] = 1'b1;
		end
		if (wr_flg && !alu_go && !ld16_go && !st_go && !acc_to_flags_op) begin
			flags_nxt = reg_wdata;
		end
		flags_nxt = flags_nxt | crs_pkg::FLAGS_ONES;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cond_flags_reg_r <= crs_pkg::FLAGS_RST;
		end else begin
			cond_flags_reg_r <= flags_nxt;
		end
	end

	// A mask that clear_mask_op or acc_to_flags_op took from one to zero holds interrupts off until the next instruction ends.
	always_comb begin
		inhib_nxt = inhib_r;
		if (instr_done) begin
			inhib_nxt = 1'b0;
		end
		if ((clear_mask_op || acc_to_flags_op) && cond_flags_reg_r[crs_pkg::FLG_I] && !flags_nxt[crs_pkg::FLG_I]) begin
			inhib_nxt = 1'b1;
		end
	end

	assign ge_nxt = ~(flags_nxt[crs_pkg::FLG_N] ^ flags_nxt[crs_pkg::FLG_V]);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			inhib_r <= 1'b0;
			irq_ok_r <= 1'b0;
			branch_greater_op_r <= 1'b0;
			branch_greater_equal_op_r <= 1'b0;
			branch_less_equal_op_r <= 1'b0;
			branch_less_op_r <= 1'b0;
		end else begin
			inhib_r <= inhib_nxt;
			irq_ok_r <= irq_pending & ~flags_nxt[crs_pkg::FLG_I] & ~inhib_nxt;
			branch_greater_op_r <= ge_nxt & ~flags_nxt[crs_pkg::FLG_Z];
			branch_greater_equal_op_r <= ge_nxt;
			branch_less_equal_op_r <= ~ge_nxt | flags_nxt[crs_pkg::FLG_Z];
			branch_less_op_r <= ~ge_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || !reg_rd) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_addr == crs_pkg::REG_ACC) begin
			reg_rdata_r <= acc_r;
		end else if (reg_addr == crs_pkg::REG_IDX_LO) begin
			reg_rdata_r <= idx_lo_r;
		end else if (reg_addr == crs_pkg::REG_IDX_HI) begin
			reg_rdata_r <= idx_hi_r;
		end else if (reg_addr == crs_pkg::REG_SP_HI) begin
			reg_rdata_r <= stack_ptr_r[15:8];
		end else if (reg_addr == crs_pkg::REG_SP_LO) begin
			reg_rdata_r <= stack_ptr_r[7:0];
		end else if (reg_addr == crs_pkg::REG_PC_HI) begin
			reg_rdata_r <= prog_counter_r[15:8];
		end else if (reg_addr == crs_pkg::REG_PC_LO) begin
			reg_rdata_r <= prog_counter_r[7:0];
		end else begin
			reg_rdata_r <= cond_flags_reg_r;
		end
	end

	AST_SP_RESET: assert property (@(posedge sys_clk) srst |=> stack_ptr_r == crs_pkg::SP_RST)
		else $error("stack pointer not 00ff after reset");
	AST_IDX_HI_RESET: assert property (@(posedge sys_clk) srst |=> idx_hi_r == crs_pkg::IDX_HI_RST)
		else $error("high index byte not cleared by reset");
	AST_FIXED_ONES: assert property (@(posedge sys_clk) disable iff (srst) cond_flags_reg_r[6:5] == 2'b11)
		else $error("flag bits 6 and 5 not one");
	AST_PC_FETCH: assert property (@(posedge sys_clk) disable iff (srst)
		boot_r == crs_pkg::RUN && pc_fetch && !pc_load |=> prog_counter_r == $past(prog_counter_r) + 16'h0001)
		else $error("program counter did not step after fetch");
	AST_PC_JUMP: assert property (@(posedge sys_clk) disable iff (srst)
		boot_r == crs_pkg::RUN && pc_load |=> prog_counter_r == $past(pc_target))
		else $error("program counter did not take the target");
	AST_VECTOR: assert property (@(posedge sys_clk) disable iff (srst)
		boot_r == crs_pkg::VEC_LO ##1 1'b1 |=> prog_counter_r == {$past(mem_rdata, 2), $past(mem_rdata)})
		else $error("program counter not loaded from vector");
	AST_BOOT_TIME: assert property (@(posedge sys_clk) $fell(srst) |-> !core_ready_r [*3] ##1 core_ready_r)
		else $error("vector fetch did not finish in three cycles");
	AST_AIS: assert property (@(posedge sys_clk) disable iff (srst)
		add_imm_to_stack && !ld16_go |=> stack_ptr_r == $past(stack_ptr_r) + {{8{$past(stack_imm[7])}}, $past(stack_imm)})
		else $error("stack add used wrong sign extension");
	AST_RSP: assert property (@(posedge sys_clk) disable iff (srst)
		stack_low_reset_op && !ld16_go && !add_imm_to_stack
		|=> stack_ptr_r[15:8] == $past(stack_ptr_r[15:8]) && stack_ptr_r[7:0] == 8'hff)
		else $error("stack low reset touched the high byte");
	AST_IRQ_MASK: assert property (@(posedge sys_clk) disable iff (srst)
		irq_take |=> cond_flags_reg_r[3] && !irq_ok_r)
		else $error("mask not set on interrupt entry");
	AST_CLI_SHADOW: assert property (@(posedge sys_clk) disable iff (srst)
		clear_mask_op && cond_flags_reg_r[3] && !instr_done |=> !irq_ok_r)
		else $error("interrupt recognised right after mask clear");
	AST_LOAD_ZN: assert property (@(posedge sys_clk) disable iff (srst)
		ld16_go && !alu_go && !acc_to_flags_op && !reg_wr
		|=> cond_flags_reg_r[1] == ($past(ld16_data) == 16'h0000) && cond_flags_reg_r[2] == $past(ld16_data[15]))
		else $error("load did not set zero and negative flags");
	AST_ACC_KEEP: assert property (@(posedge sys_clk) srst && !reg_wr && !alu_go |=> acc_r == $past(acc_r))
		else $error("accumulator changed by reset");
endmodule // crs_regset
`default_nettype wire

// ==== crs_regset_tb.sv ====
// Self-checking bench for the processor register set.
`timescale 1ns/1ns
`default_nettype none
module crs_regset_tb;
	localparam logic [15:0] VECTOR = 16'hc3a5;
	logic sys_clk, srst, alu_go, alu_to_idx, ld16_go, ld16_to_sp, st_go, st_wide, idx_post_inc, add_imm_to_stack;
	logic stack_low_reset_op, sp_push, sp_pull, pc_fetch, pc_load, clear_mask_op, set_mask_op, acc_to_flags_op;
	logic irq_take, irq_pending, instr_done, carry_set_go, carry_val, reg_wr, reg_rd;
	crs_pkg::crs_alu_op_e alu_op;
	logic [7:0] alu_operand, stack_imm, mem_rdata, reg_wdata, reg_rdata_r, acc_r, idx_hi_r, idx_lo_r, cond_flags_reg_r;
	logic [15:0] ld16_data, st_data, pc_target, stack_ptr_r, prog_counter_r, vec_addr_r, rnd, sp;
	logic [2:0] reg_addr;
	logic branch_greater_op_r, branch_greater_equal_op_r, branch_less_equal_op_r, branch_less_op_r;
	logic irq_ok_r, vec_rd_r, core_ready_r;
	logic [7:0] a, b, d;
	logic [10:0] e;
	int n_errors = 0;
	int cmp_count = 0;

	crs_regset dut (.sys_clk, .srst, .alu_go, .alu_op, .alu_to_idx, .alu_operand, .ld16_go, .ld16_to_sp, .ld16_data,
		.st_go, .st_wide, .st_data, .idx_post_inc, .add_imm_to_stack, .stack_imm, .stack_low_reset_op, .sp_push,
		.sp_pull, .pc_fetch, .pc_load, .pc_target, .mem_rdata, .clear_mask_op, .set_mask_op, .acc_to_flags_op,
		.irq_take, .irq_pending, .instr_done, .carry_set_go, .carry_val, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata_r, .acc_r, .idx_hi_r, .idx_lo_r, .stack_ptr_r, .prog_counter_r, .cond_flags_reg_r,
		.branch_greater_op_r, .branch_greater_equal_op_r, .branch_less_equal_op_r, .branch_less_op_r, .irq_ok_r,
		.vec_rd_r, .vec_addr_r, .core_ready_r);
	crs_vec_mem #(.VECTOR(VECTOR)) mem (.sys_clk, .vec_rd(vec_rd_r), .vec_addr(vec_addr_r), .mem_rdata);

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Returns overflow, half carry, carry and the sum.
	function automatic logic [10:0] add_ref(input logic [7:0] x, input logic [7:0] y);
		logic [8:0] s;
		logic [4:0] l;
		s = x + y;
		l = x[3:0] + y[3:0];
		return {(x[7] == y[7]) && (s[7] != x[7]), l[4], s};
	endfunction

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Drops every strobe but set_mask_op at the edge that takes it, then lets the updates land.
	task automatic fin;
		@(posedge sys_clk);
		{alu_go, ld16_go, st_go, idx_post_inc, add_imm_to_stack, stack_low_reset_op, sp_push, sp_pull, pc_fetch,
			pc_load, clear_mask_op, acc_to_flags_op, irq_take, instr_done, carry_set_go, reg_wr, reg_rd} <= '0;
		#1;
	endtask

	task automatic alu(input crs_pkg::crs_alu_op_e op, input logic to_idx, input logic [7:0] opnd);
		@(posedge sys_clk);
		alu_go <= 1'b1;
		alu_op <= op;
		alu_to_idx <= to_idx;
		alu_operand <= opnd;
		fin;
	endtask

	task automatic reg_write(input logic [2:0] ad, input logic [7:0] wd);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= wd;
		fin;
	endtask

	task automatic reg_read(input logic [2:0] ad, output logic [7:0] rd);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		fin;
		rd = reg_rdata_r;
	endtask

	task automatic boot;
		@(posedge sys_clk);
		srst <= 1'b0;
		// Let the reset edge land first, or a ready left from an earlier run ends the wait at once.
		#1;
		for (int i = 0; i < 12 && core_ready_r !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		chk("core_ready", 16'h1, core_ready_r);
		chk("prog_counter", VECTOR, prog_counter_r);
		chk("idx_hi", 16'h0, idx_hi_r);
		chk("stack_ptr", crs_pkg::SP_RST, stack_ptr_r);
		chk("flag_ones", 16'h60, cond_flags_reg_r & 8'h60);
	endtask

	initial begin
		{alu_go, alu_to_idx, ld16_go, ld16_to_sp, st_go, st_wide, idx_post_inc, add_imm_to_stack, stack_low_reset_op,
			sp_push, sp_pull, pc_fetch, pc_load, clear_mask_op, set_mask_op, acc_to_flags_op, irq_take, irq_pending,
			instr_done, carry_set_go, carry_val, reg_wr, reg_rd, alu_operand, stack_imm, reg_wdata, ld16_data,
			st_data, pc_target, reg_addr} = '0;
		alu_op = crs_pkg::ALU_ADD;
		srst = 1'b1;
		rnd = 16'd26712;
		// The accumulator has no reset, so it is given a value in the first reset cycle.
		reg_wr = 1'b1;
		reg_wdata = 8'h3c;
		fin;
		repeat (11) @(posedge sys_clk);
		boot;
		chk("acc", 16'h3c, acc_r);
		// The first three pairs hit signed overflow, both carries and a zero sum.
		for (int i = 0; i < 12; i++) begin
			rnd = lfsr(rnd);
			a = (i == 0) ? 8'h7f : (i == 1) ? 8'h88 : (i == 2) ? 8'h00 : rnd[7:0];
			b = (i == 0) ? 8'h01 : (i == 1) ? 8'h88 : (i == 2) ? 8'h00 : rnd[15:8];
			alu(crs_pkg::ALU_LOAD, 1'b0, a);
			chk("acc", a, acc_r);
			chk("neg_zero", {a[7], a == 8'h00}, cond_flags_reg_r[2:1]);
			alu(crs_pkg::ALU_ADD, 1'b0, b);
			e = add_ref(a, b);
			chk("acc_sum", e[7:0], acc_r);
			chk("flags", {e[10], 2'b11, e[9], 1'b1, e[7], e[7:0] == 8'h00, e[8]}, cond_flags_reg_r);
			chk("signed_lt", e[10] ^ e[7], branch_less_op_r);
			chk("signed_ge", !(e[10] ^ e[7]), branch_greater_equal_op_r);
			chk("signed_gt", !(e[10] ^ e[7]) && e[7:0] != 8'h00, branch_greater_op_r);
			chk("signed_le", (e[10] ^ e[7]) || e[7:0] == 8'h00, branch_less_equal_op_r);
		end
		// A half carry out of 9 + 8 must trigger the low-digit decimal fix.
		alu(crs_pkg::ALU_LOAD, 1'b0, 8'h19);
		alu(crs_pkg::ALU_ADD, 1'b0, 8'h28);
		alu(crs_pkg::ALU_DAA, 1'b0, 8'h00);
		chk("bcd_sum", 16'h47, acc_r);
		chk("bcd_carry", 16'h0, cond_flags_reg_r[crs_pkg::FLG_C]);
		alu(crs_pkg::ALU_LOAD, 1'b0, 8'h10);
		alu(crs_pkg::ALU_SUB, 1'b0, 8'h20);
		chk("acc_diff", 16'hf0, acc_r);
		chk("borrow", 16'h1, cond_flags_reg_r[crs_pkg::FLG_C]);
		alu(crs_pkg::ALU_LSR, 1'b0, 8'h00);
		chk("acc_shift", 16'h78, acc_r);
		chk("shift_carry", 16'h0, cond_flags_reg_r[crs_pkg::FLG_C]);
		@(posedge sys_clk);
		ld16_go <= 1'b1;
		ld16_data <= 16'h00ff;
		fin;
		chk("index_pair", 16'h00ff, {idx_hi_r, idx_lo_r});
		@(posedge sys_clk);
		idx_post_inc <= 1'b1;
		fin;
		chk("index_pair", 16'h0100, {idx_hi_r, idx_lo_r});
		alu(crs_pkg::ALU_DEC, 1'b1, 8'h00);
		chk("index_pair", 16'h01ff, {idx_hi_r, idx_lo_r});
		chk("neg", 16'h1, cond_flags_reg_r[crs_pkg::FLG_N]);
		sp = crs_pkg::SP_RST;
		for (int i = 0; i < 5; i++) begin
			rnd = lfsr(rnd);
			@(posedge sys_clk);
			add_imm_to_stack <= 1'b1;
			stack_imm <= (i == 0) ? 8'h80 : rnd[7:0];
			fin;
			sp = sp + {{8{stack_imm[7]}}, stack_imm};
			chk("stack_ptr", sp, stack_ptr_r);
		end
		@(posedge sys_clk);
		ld16_go <= 1'b1;
		ld16_to_sp <= 1'b1;
		ld16_data <= 16'h1234;
		fin;
		@(posedge sys_clk);
		stack_low_reset_op <= 1'b1;
		fin;
		chk("stack_ptr", 16'h12ff, stack_ptr_r);
		@(posedge sys_clk);
		sp_push <= 1'b1;
		fin;
		chk("stack_ptr", 16'h12fe, stack_ptr_r);
		@(posedge sys_clk);
		sp_pull <= 1'b1;
		fin;
		chk("stack_ptr", 16'h12ff, stack_ptr_r);
		@(posedge sys_clk);
		pc_fetch <= 1'b1;
		fin;
		chk("prog_counter", VECTOR + 16'h1, prog_counter_r);
		@(posedge sys_clk);
		pc_fetch <= 1'b1;
		pc_load <= 1'b1;
		pc_target <= rnd;
		fin;
		chk("prog_counter", rnd, prog_counter_r);
		@(posedge sys_clk);
		st_go <= 1'b1;
		st_wide <= 1'b1;
		st_data <= 16'h8000;
		irq_pending <= 1'b1;
		fin;
		chk("neg_zero", 16'h2, cond_flags_reg_r[2:1]);
		@(posedge sys_clk);
		st_go <= 1'b1;
		st_wide <= 1'b0;
		fin;
		chk("neg_zero", 16'h1, cond_flags_reg_r[2:1]);
		@(posedge sys_clk);
		carry_set_go <= 1'b1;
		carry_val <= 1'b1;
		fin;
		chk("carry", 16'h1, cond_flags_reg_r[crs_pkg::FLG_C]);
		chk("irq_ok", 16'h0, irq_ok_r);
		@(posedge sys_clk);
		clear_mask_op <= 1'b1;
		fin;
		chk("mask", 16'h0, cond_flags_reg_r[crs_pkg::FLG_I]);
		chk("irq_ok", 16'h0, irq_ok_r);
		@(posedge sys_clk);
		instr_done <= 1'b1;
		fin;
		chk("irq_ok", 16'h1, irq_ok_r);
		@(posedge sys_clk);
		irq_take <= 1'b1;
		fin;
		chk("mask", 16'h1, cond_flags_reg_r[crs_pkg::FLG_I]);
		chk("irq_ok", 16'h0, irq_ok_r);
		// Copying the accumulator into the flags clears the mask and opens the same shadow.
		reg_write(crs_pkg::REG_ACC, 8'h01);
		@(posedge sys_clk);
		acc_to_flags_op <= 1'b1;
		fin;
		chk("flags_tap", 16'h61, cond_flags_reg_r);
		chk("irq_ok", 16'h0, irq_ok_r);
		@(posedge sys_clk);
		instr_done <= 1'b1;
		fin;
		chk("irq_ok", 16'h1, irq_ok_r);
		reg_write(crs_pkg::REG_FLAGS, 8'h00);
		reg_read(crs_pkg::REG_FLAGS, d);
		chk("flags_read", 16'h60, d);
		reg_read(crs_pkg::REG_SP_HI, d);
		chk("sp_hi_read", 16'h12, d);
		reg_write(crs_pkg::REG_ACC, 8'ha5);
		// A second reset must leave the accumulator and low index byte alone.
		@(posedge sys_clk);
		srst <= 1'b1;
		boot;
		chk("acc", 16'ha5, acc_r);
		chk("idx_lo", 16'hff, idx_lo_r);
		test_done;
	end

	initial begin
		repeat (2000) @(posedge sys_clk);
		n_errors++;
		test_done;
	end
endmodule // crs_regset_tb
`default_nettype wire

// ==== crs_vec_mem.sv ====
// Memory model that answers the reset vector fetch of the register set.
`timescale 1ns/1ns
`default_nettype none
module crs_vec_mem #(
	parameter logic [15:0] VECTOR = 16'hc3a5
) (
	input wire logic sys_clk,
	input wire logic vec_rd,
	input wire logic [15:0] vec_addr,
	output logic [7:0] mem_rdata
);
	initial mem_rdata = 8'h5a;
	always @(posedge sys_clk) begin
		if (vec_rd && vec_addr == crs_pkg::VEC_HI_ADDR) begin
			mem_rdata <= VECTOR[15:8];
		end else if (vec_rd && vec_addr == crs_pkg::VEC_LO_ADDR) begin
			mem_rdata <= VECTOR[7:0];
		end else begin
			// An idle bus must not look like a held vector byte.
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule // crs_vec_mem
`default_nettype wire
